// ---- hdl/timer_pkg.sv ----
// constants for the dual timer block
package timer_pkg;
  // register digit addresses
  localparam logic [3:0] ADDR_A_IRQ = 4'h1;
  localparam logic [3:0] ADDR_B_IRQ = 4'h2;
  localparam logic [3:0] ADDR_A_MODE = 4'h8;
  localparam logic [3:0] ADDR_B_MODE = 4'h9;
  localparam logic [3:0] ADDR_B_LOW = 4'hA;
  localparam logic [3:0] ADDR_B_HIGH = 4'hB;
  // field positions
  localparam int A_FLAG_BIT = 2;
  localparam int A_MASK_BIT = 3;
  localparam int B_FLAG_BIT = 0;
  localparam int B_MASK_BIT = 1;
  localparam int B_RELOAD_BIT = 3;
  // widths and reset values
  localparam int PRESCALE_W = 11;
  localparam int COUNT_W = 8;
  localparam logic [10:0] PRESCALE_RST = 11'h000;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [2:0] A_MODE_RST = 3'h0;
  localparam logic [3:0] B_MODE_RST = 4'h0;
  localparam logic [2:0] B_SEL_EXT = 3'h7;
  localparam logic IRQ_MASK_RST = 1'b1;
  // mode change takes effect at the second instruction cycle
  localparam int B_MODE_DELAY = 2;
endpackage

// ---- hdl/mode_delay.sv ----
// delay line that applies a written mode after a fixed number of cycles
`timescale 1ns/10ps
module mode_delay (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // new mode in
  input wire logic wr_stb,
  input wire logic [3:0] wr_data,
  // effective mode out
  output logic [3:0] mode_q
);
  logic [3:0] pend_q;
  logic [1:0] age_q;

  // hold the written value and count cycles until it becomes effective
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= timer_pkg::B_MODE_RST;
      age_q <= 2'h0;
      mode_q <= timer_pkg::B_MODE_RST;
    end else if (clk_en) begin
      if (wr_stb) begin
        pend_q <= wr_data;
        age_q <= 2'(timer_pkg::B_MODE_DELAY - 1);
      end else if (age_q != 2'h0) begin
        age_q <= age_q - 2'h1;
        if (age_q == 2'h1) begin
          mode_q <= pend_q;
        end
      end
    end
  end
endmodule

// ---- hdl/dual_timer_with_reload.sv ----
// prescaler, free-running timer a and auto-reload timer b with digit registers
// Summary of operation
// - mode b bit 3 enables auto-reload
// - mode b low bits pick tap or event
// - mode a bits pick prescaler tap
// - mode a: 3-bit, write-only, reset zero
// - mode b: 4-bit, write-only, reset zero
// - mode b change applies two cycles later
// - timer b increments per selected pulse
// - b overflow reloads load value or zero
// - b overflow sets b request flag
// - a overflow sets a request flag
// - a mask bit blocks a request
// - b mask bit blocks b request
// - load write-only, counter read-only, shared addresses
// - high digit write loads the counter
// - high read latches low digit
// - reset clears load register
// - timer a wraps, overflows every 256
// - 11-bit prescaler runs except in reset, in stop mode or with enable low
`timescale 1ns/10ps
module dual_timer_with_reload (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // external event pin and stop mode
  input wire logic ext_event_input,
  input wire logic stop_mode,
  // interrupt requests
  output logic timer_a_irq,
  output logic timer_b_irq
);
  logic [10:0] prescale_q;
  logic [10:0] prescale_d;
  logic [2:0] timer_a_mode_q;
  logic [3:0] timer_b_mode_q;
  logic [3:0] load_low_q;
  logic [7:0] load_q;
  logic [7:0] count_a_q;
  logic [7:0] count_b_q;
  logic [3:0] low_latch_q;
  logic timer_a_irq_flag_q;
  logic timer_a_irq_mask_q;
  logic timer_b_irq_flag_q;
  logic timer_b_irq_mask_q;
  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  logic tick_a;
  logic tick_b;
  logic ovf_a;
  logic ovf_b;
  logic wr_b_high;
  logic [3:0] rdata_d;

  // rising edge of a prescaler bit is one tap pulse
  function automatic logic tap_edge(input logic [10:0] cur, input logic [10:0] nxt,
                                    input int idx);
    tap_edge = !cur[idx] && nxt[idx];
  endfunction

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] addr, input logic wr);
    wr_hit = wr && (a == addr);
  endfunction

  assign prescale_d = prescale_q + 11'h001;

  // prescaler counts while enable is high and not in stop mode; reset clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_q <= timer_pkg::PRESCALE_RST;
    end else if (clk_en && !stop_mode) begin
      prescale_q <= prescale_d;
    end
  end

  // tap for divide by 2^(n): bit n-1 rises once per 2^n clocks
  always_comb begin
    tick_a = 1'b0;
    if (clk_en && !stop_mode) begin
      unique case (timer_a_mode_q)
        3'h0: tick_a = tap_edge(prescale_q, prescale_d, 10);
        3'h1: tick_a = tap_edge(prescale_q, prescale_d, 9);
        3'h2: tick_a = tap_edge(prescale_q, prescale_d, 8);
        3'h3: tick_a = tap_edge(prescale_q, prescale_d, 6);
        3'h4: tick_a = tap_edge(prescale_q, prescale_d, 4);
        3'h5: tick_a = tap_edge(prescale_q, prescale_d, 2);
        3'h6: tick_a = tap_edge(prescale_q, prescale_d, 1);
        3'h7: tick_a = tap_edge(prescale_q, prescale_d, 0);
      endcase
    end
  end

  // external event pin synchronised, then edge detected behind second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else if (clk_en) begin
      ev_s1_q <= ext_event_input;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  // timer b source; event counting keeps running in stop so pin edges are not lost
  always_comb begin
    tick_b = 1'b0;
    if (clk_en) begin
      unique case (timer_b_mode_q[2:0])
        3'h0: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 10);
        3'h1: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 8);
        3'h2: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 6);
        3'h3: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 4);
        3'h4: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 2);
        3'h5: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 1);
        3'h6: tick_b = !stop_mode && tap_edge(prescale_q, prescale_d, 0);
        3'h7: tick_b = !ev_s3_q && ev_s2_q; // event on rising pin edge
      endcase
    end
  end

  // overflow is the tick that finds a counter at its top value
  assign ovf_a = tick_a && (count_a_q == timer_pkg::COUNT_MAX);
  assign ovf_b = tick_b && (count_b_q == timer_pkg::COUNT_MAX);
  assign wr_b_high = clk_en && wr_hit(timer_pkg::ADDR_B_HIGH, reg_addr, reg_wr);

  // timer a mode register, write-only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_a_mode_q <= timer_pkg::A_MODE_RST;
    end else if (clk_en && wr_hit(timer_pkg::ADDR_A_MODE, reg_addr, reg_wr)) begin
      timer_a_mode_q <= reg_wdata[2:0];
    end
  end

  // timer b mode goes through the delay line
  mode_delay u_mode_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr_stb(wr_hit(timer_pkg::ADDR_B_MODE, reg_addr, reg_wr)),
    .wr_data(reg_wdata),
    .mode_q(timer_b_mode_q)
  );

  // load register: low digit staged, whole byte taken on high digit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_low_q <= 4'h0;
      load_q <= timer_pkg::COUNT_RST;
    end else if (clk_en) begin
      if (wr_hit(timer_pkg::ADDR_B_LOW, reg_addr, reg_wr)) begin
        load_low_q <= reg_wdata;
      end
      if (wr_b_high) begin
        load_q <= {reg_wdata, load_low_q};
      end
    end
  end

  // timer a: free running, wraps to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_a_q <= timer_pkg::COUNT_RST;
    end else if (tick_a) begin
      count_a_q <= count_a_q + 8'h01; // wraps naturally at ff
    end
  end

  // timer b: high digit write beats a tick in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_b_q <= timer_pkg::COUNT_RST;
    end else if (wr_b_high) begin
      count_b_q <= {reg_wdata, load_low_q};
    end else if (ovf_b) begin
      count_b_q <= timer_b_mode_q[timer_pkg::B_RELOAD_BIT] ? load_q
                                                           : timer_pkg::COUNT_RST;
    end else if (tick_b) begin
      count_b_q <= count_b_q + 8'h01;
    end
  end

  // low digit latch on high read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_latch_q <= 4'h0;
    end else if (clk_en && reg_rd && reg_addr == timer_pkg::ADDR_B_HIGH) begin
      low_latch_q <= count_b_q[3:0];
    end
  end

  // flags and masks; hardware set wins over software clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_a_irq_flag_q <= 1'b0;
      timer_a_irq_mask_q <= timer_pkg::IRQ_MASK_RST;
      timer_b_irq_flag_q <= 1'b0;
      timer_b_irq_mask_q <= timer_pkg::IRQ_MASK_RST;
    end else if (clk_en) begin
      if (wr_hit(timer_pkg::ADDR_A_IRQ, reg_addr, reg_wr)) begin
        timer_a_irq_flag_q <= reg_wdata[timer_pkg::A_FLAG_BIT] || ovf_a;
        timer_a_irq_mask_q <= reg_wdata[timer_pkg::A_MASK_BIT];
      end else if (ovf_a) begin
        timer_a_irq_flag_q <= 1'b1;
      end
      if (wr_hit(timer_pkg::ADDR_B_IRQ, reg_addr, reg_wr)) begin
        timer_b_irq_flag_q <= reg_wdata[timer_pkg::B_FLAG_BIT] || ovf_b;
        timer_b_irq_mask_q <= reg_wdata[timer_pkg::B_MASK_BIT];
      end else if (ovf_b) begin
        timer_b_irq_flag_q <= 1'b1;
      end
    end
  end

  assign timer_a_irq = timer_a_irq_flag_q && !timer_a_irq_mask_q;
  assign timer_b_irq = timer_b_irq_flag_q && !timer_b_irq_mask_q;

  // read mux; write-only registers and unmapped digits read zero
  always_comb begin
    rdata_d = 4'h0;
    if (reg_addr == timer_pkg::ADDR_A_IRQ) begin
      rdata_d[timer_pkg::A_FLAG_BIT] = timer_a_irq_flag_q;
      rdata_d[timer_pkg::A_MASK_BIT] = timer_a_irq_mask_q;
    end else if (reg_addr == timer_pkg::ADDR_B_IRQ) begin
      rdata_d[timer_pkg::B_FLAG_BIT] = timer_b_irq_flag_q;
      rdata_d[timer_pkg::B_MASK_BIT] = timer_b_irq_mask_q;
    end else if (reg_addr == timer_pkg::ADDR_B_LOW) begin
      rdata_d = low_latch_q;
    end else if (reg_addr == timer_pkg::ADDR_B_HIGH) begin
      rdata_d = count_b_q[7:4];
    end
  end

  // read data register, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 4'h0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 4'h0;
    end
  end

  // software side: external interrupt masked when counting events load
  // high is rewritten after a mode change nothing here depends on it

  // assertions
  // named steps of the multi-access sequences that software promises to keep
  sequence s_high_read;
    clk_en && reg_rd && reg_addr == timer_pkg::ADDR_B_HIGH;
  endsequence
  sequence s_low_read;
    clk_en && reg_rd && reg_addr == timer_pkg::ADDR_B_LOW;
  endsequence
  sequence s_mode_b_write;
    clk_en && reg_wr && reg_addr == timer_pkg::ADDR_B_MODE;
  endsequence
  sequence s_quiet_cycle;
    clk_en && !reg_wr;
  endsequence

  // overflow sets the request flags
  a_a_overflow_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ovf_a |=> timer_a_irq_flag_q)
    else $error("timer a overflow did not set flag");
  a_b_overflow_flag: assert property (@(posedge clk) disable iff (sys_rst)
    ovf_b |=> timer_b_irq_flag_q)
    else $error("timer b overflow did not set flag");

  // flags fall only by a software write, so a request is never lost
  a_a_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
    timer_a_irq_flag_q && !(clk_en && wr_hit(timer_pkg::ADDR_A_IRQ, reg_addr, reg_wr))
    |=> timer_a_irq_flag_q)
    else $error("timer a flag fell without a write");
  a_b_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
    timer_b_irq_flag_q && !(clk_en && wr_hit(timer_pkg::ADDR_B_IRQ, reg_addr, reg_wr))
    |=> timer_b_irq_flag_q)
    else $error("timer b flag fell without a write");

  // timer a counts only on its tap and wraps to zero
  a_a_wrap_zero: assert property (@(posedge clk) disable iff (sys_rst)
    ovf_a |=> count_a_q == timer_pkg::COUNT_RST)
    else $error("timer a did not wrap to zero");
  a_a_increment: assert property (@(posedge clk) disable iff (sys_rst)
    tick_a && !ovf_a |=> count_a_q == $past(count_a_q) + 8'h01)
    else $error("timer a did not increment");
  a_a_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !tick_a |=> $stable(count_a_q))
    else $error("timer a moved without a tick");

  // timer b counts, reloads and takes the high digit write
  a_b_reload_value: assert property (@(posedge clk) disable iff (sys_rst)
    ovf_b && !wr_b_high |=> count_b_q == ($past(timer_b_mode_q[timer_pkg::B_RELOAD_BIT])
      ? $past(load_q) : timer_pkg::COUNT_RST))
    else $error("timer b reload value wrong");
  a_b_high_load: assert property (@(posedge clk) disable iff (sys_rst)
    wr_b_high |=> count_b_q == {$past(reg_wdata), $past(load_low_q)})
    else $error("high digit write did not load counter");
  a_b_increment: assert property (@(posedge clk) disable iff (sys_rst)
    tick_b && !ovf_b && !wr_b_high |=> count_b_q == $past(count_b_q) + 8'h01)
    else $error("timer b did not increment");
  a_b_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !tick_b && !wr_b_high |=> $stable(count_b_q))
    else $error("timer b moved without a tick");

  // register reads and interrupt gating
  a_low_latch: assert property (@(posedge clk) disable iff (sys_rst)
    s_high_read ##1 s_low_read |=> reg_rdata == $past(count_b_q[3:0], 2))
    else $error("low digit not latched at high read");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !reg_rd |=> reg_rdata == 4'h0)
    else $error("read data not zero outside a read");
  a_irq_gating: assert property (@(posedge clk) disable iff (sys_rst)
    timer_b_irq == (timer_b_irq_flag_q && !timer_b_irq_mask_q) &&
    timer_a_irq == (timer_a_irq_flag_q && !timer_a_irq_mask_q))
    else $error("interrupt gating wrong");

  // prescaler advance and enable freeze
  a_prescale_run: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !stop_mode |=> prescale_q == $past(prescale_q) + 11'h001)
    else $error("prescaler did not advance");
  a_enable_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(prescale_q) && $stable(count_a_q) && $stable(count_b_q))
    else $error("state moved while enable was low");

  // mode b: unchanged one cycle on, applied the cycle after
  a_mode_b_early: assert property (@(posedge clk) disable iff (sys_rst)
    s_mode_b_write |=> timer_b_mode_q == $past(timer_b_mode_q))
    else $error("timer b mode applied too early");
  a_mode_b_delay: assert property (@(posedge clk) disable iff (sys_rst)
    s_mode_b_write ##1 s_quiet_cycle ##1 clk_en |-> timer_b_mode_q == $past(reg_wdata, 2))
    else $error("timer b mode not applied after two cycles");
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the dual timer block
`timescale 1ns/10ps
module tb_top;
  // clocking
  logic clk;
  logic sys_rst;
  logic clk_en;
  // register port
  logic [3:0] reg_addr;
  logic [3:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_rdata;
  // pins
  logic ext_event_input;
  logic stop_mode;
  logic timer_a_irq;
  logic timer_b_irq;
  int num_errors;
  int checks_done;
  int cycles = 0;

  dual_timer_with_reload u_dual_timer_with_reload (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_event_input(ext_event_input), .stop_mode(stop_mode),
    .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq)
  );

  // 25 ns period clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, taken at the following edge
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [3:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  // high digit first so the low digit is latched together with it
  task automatic rd_cnt(input logic [7:0] exp);
    rd(timer_pkg::ADDR_B_HIGH, exp[7:4]);
    rd(timer_pkg::ADDR_B_LOW, exp[3:0]);
  endtask

  task automatic load_b(input logic [7:0] v);
    wr(timer_pkg::ADDR_B_LOW, v[3:0]);
    wr(timer_pkg::ADDR_B_HIGH, v[7:4]);
  endtask

  // long enough for the two-flop synchroniser and edge detect
  task automatic pulse();
    @(posedge clk);
    ext_event_input <= 1'b1;
    repeat (4) @(posedge clk);
    ext_event_input <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic chk_irq(input logic a, input logic b);
    @(negedge clk);
    check({6'h00, timer_a_irq, timer_b_irq}, {6'h00, a, b});
  endtask

  // hang guard: the sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_event_input = 1'b0;
    // prescaler frozen so timer b moves only on events
    stop_mode = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, write-only and unmapped digits read zero
    rd(timer_pkg::ADDR_A_IRQ, 4'h8);
    rd(timer_pkg::ADDR_B_IRQ, 4'h2);
    rd(timer_pkg::ADDR_A_MODE, 4'h0);
    rd(timer_pkg::ADDR_B_MODE, 4'h0);
    rd(4'h5, 4'h0);
    rd_cnt(8'h00);
    chk_irq(1'b0, 1'b0);
    // event counting with auto-reload
    wr(timer_pkg::ADDR_B_MODE, 4'hF); // b irq mask cleared in this block, set again in the no-reload block
    load_b(8'hFE);
    rd_cnt(8'hFE);
    pulse();
    rd_cnt(8'hFF);
    pulse();
    rd_cnt(8'hFE);
    rd(timer_pkg::ADDR_B_IRQ, 4'h3);
    chk_irq(1'b0, 1'b0);
    wr(timer_pkg::ADDR_B_IRQ, 4'h1);
    chk_irq(1'b0, 1'b1);
    wr(timer_pkg::ADDR_B_IRQ, 4'h0);
    chk_irq(1'b0, 1'b0);
    // no reload: overflow goes to zero
    wr(timer_pkg::ADDR_B_MODE, 4'h7);
    load_b(8'hFF);
    pulse();
    rd_cnt(8'h00);
    chk_irq(1'b0, 1'b1);
    wr(timer_pkg::ADDR_B_IRQ, 4'h2);
    // low digit latched at the high read
    load_b(8'h0F);
    rd(timer_pkg::ADDR_B_HIGH, 4'h0);
    pulse();
    rd(timer_pkg::ADDR_B_LOW, 4'hF);
    rd_cnt(8'h10);
    // timer a on the divide-by-2 tap: overflow after 512 clocks
    wr(timer_pkg::ADDR_A_MODE, 4'h7);
    wr(timer_pkg::ADDR_A_IRQ, 4'h0);
    stop_mode <= 1'b0;
    repeat (470) @(posedge clk);
    rd(timer_pkg::ADDR_A_IRQ, 4'h0);
    chk_irq(1'b0, 1'b0);
    repeat (60) @(posedge clk);
    rd(timer_pkg::ADDR_A_IRQ, 4'h4);
    chk_irq(1'b1, 1'b0);
    wr(timer_pkg::ADDR_A_IRQ, 4'hC);
    chk_irq(1'b0, 1'b0);
    // divide-by-4 tap for timer b; 8 clocks with enable low must not count
    wr(timer_pkg::ADDR_B_MODE, 4'h5);
    load_b(8'h20);
    clk_en <= 1'b0;
    repeat (8) @(posedge clk);
    clk_en <= 1'b1;
    repeat (11) @(posedge clk);
    rd_cnt(8'h23);
    final_report();
  end
endmodule
